/* File: verilog/dvr_ctrl.sv */
// volume, mute and level-ramp control with an apb register file
// assumes samples and ratio error come from logic on pclk (the master
// clock); frame clock, bitstream clock and the mute sense pin are async
`timescale 1ns/1ps
`default_nettype none

module dvr_ctrl
  import dvr_pkg::*;
#(
  parameter int SAMPLE_W = 24,
  parameter int AUTO_MUTE_SAMPLES = 8192
) (
  input wire logic pclk, // master clock
  input wire logic presetn, // async reset
  input wire logic [7:0] paddr, // apb byte address
  input wire logic psel, // apb
  input wire logic penable, // apb
  input wire logic pwrite, // apb
  input wire logic [31:0] pwdata, // apb
  output logic [31:0] prdata, // apb
  output logic pready, // apb
  output logic pslverr, // apb error
  input wire logic frame_clock, // pin
  input wire logic bitstream_clock, // pin
  input wire logic [SAMPLE_W-1:0] sample_a, // sample a
  input wire logic [SAMPLE_W-1:0] sample_b, // sample b
  input wire logic sample_strobe, // new pair
  input wire logic ratio_error, // error pulse
  input wire logic bitstream_128x, // 128x clock
  input wire logic mute_sense_a, // pin a sense
  output logic mute_out_a, // pin a
  output logic mute_out_a_oe, // pin a drive
  output logic mute_out_b, // pin b
  output logic mute_out_b_oe, // pin b drive
  output logic [LEVEL_W-1:0] level_a, // 1/8 dB
  output logic [LEVEL_W-1:0] level_b, // 1/8 dB
  output logic interp_rolloff_sel, // 1 slow
  output logic [1:0] deemph_select, // de-emphasis
  output logic [1:0] func_mode, // mode
  output logic bitstream_bypass, // bypass
  output logic lp50_enable, // 50k filter
  output logic volume_active, // volume on
  output logic conversion_pause, // reload
  output logic low_power_request, // low power
  output logic register_control_enable // port on
);

  localparam int ZC_W = $clog2(ZC_TIMEOUT_SAMPLES) + 1;
  localparam int AM_W = $clog2(AUTO_MUTE_SAMPLES) + 1;
  localparam int BS_W = $clog2(BS_STEP_CLKS_128X) + 1;
  localparam int RL_W = $clog2(RELOAD_CYCLES) + 1;

  function automatic logic [7:0] rst_val(input int i);
    case (i)
      IDX_MODE: rst_val = RST_MODE;
      IDX_MIX: rst_val = RST_MIX;
      IDX_MUTE: rst_val = RST_MUTE;
      IDX_RAMP: rst_val = RST_RAMP;
      IDX_PWR: rst_val = RST_PWR;
      default: rst_val = RST_ATT;
    endcase
  endfunction : rst_val

  function automatic logic [7:0] wmask(input int i);
    case (i)
      IDX_MODE: wmask = WM_MODE;
      IDX_MUTE: wmask = WM_MUTE;
      IDX_RAMP: wmask = WM_RAMP;
      IDX_PWR: wmask = WM_PWR;
      default: wmask = WM_ALL;
    endcase
  endfunction : wmask

  // ==========================================================
  // apb slave, no wait state: pready rises in the first access phase cycle
  logic [7:0] sh_q [IDX_MODE:IDX_PWR];
  logic [7:0] act_q [IDX_MODE:IDX_PWR];
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic [31:0] status_w;
  logic [31:0] rd_w;
  wire logic [5:0] idx_w = paddr[7:2];
  wire logic in_map_w = (idx_w >= 6'(IDX_MODE)) && (idx_w <= 6'(IDX_PWR));
  wire logic is_stat_w = idx_w == 6'(IDX_STAT);
  wire logic setup_w = psel && !penable;
  wire logic wr_en_w = psel && penable && pready_q && pwrite && in_map_w;
  wire logic freeze_w = sh_q[IDX_PWR][B_FREEZE];

  always_comb begin
    rd_w = 32'h0000_0000;
    if (is_stat_w) begin
      rd_w = status_w;
    end
    for (int i = IDX_MODE; i <= IDX_PWR; i++) begin
      if (idx_w == 6'(i)) begin
        rd_w = {24'h00_0000, sh_q[i]};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= setup_w;
      pslverr_q <= setup_w && !in_map_w && !is_stat_w;
      if (setup_w) begin
        prdata_q <= pwrite ? 32'h0000_0000 : rd_w;
      end
    end
  end

  // writes land in the shadow copy; the active copy follows it
  // unless frozen, so a frozen burst lands in one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = IDX_MODE; i <= IDX_PWR; i++) begin
        sh_q[i] <= rst_val(i);
        act_q[i] <= rst_val(i);
      end
    end else begin
      for (int i = IDX_MODE; i <= IDX_PWR; i++) begin
        if (wr_en_w && idx_w == 6'(i)) begin
          sh_q[i] <= pwdata[7:0] & wmask(i);
        end
        if (!freeze_w) begin
          act_q[i] <= sh_q[i];
        end
      end
    end
  end

  // ==========================================================
  // effective configuration: reset values, with low power off, until the port is enabled
  wire logic register_control_enable_w = act_q[IDX_PWR][B_REGISTER_CONTROL_ENABLE];
  wire logic [7:0] e_mode = register_control_enable_w ? act_q[IDX_MODE] : RST_MODE;
  wire logic [7:0] e_mix = register_control_enable_w ? act_q[IDX_MIX] : RST_MIX;
  wire logic [7:0] e_mute = register_control_enable_w ? act_q[IDX_MUTE] : RST_MUTE;
  wire logic [7:0] e_att_a = register_control_enable_w ? act_q[IDX_ATT_A] : RST_ATT;
  wire logic [7:0] e_att_b = register_control_enable_w ? act_q[IDX_ATT_B] : RST_ATT;
  wire logic [7:0] e_ramp = register_control_enable_w ? act_q[IDX_RAMP] : RST_RAMP;
  wire logic low_pwr_w = register_control_enable_w && act_q[IDX_PWR][B_LOWPWR];
  wire logic [1:0] fm_w = e_mode[B_FM_LO +: 2];
  wire logic bs_mode_w = fm_w == FM_BITSTREAM;
  wire logic bypass_w = e_ramp[B_BYPASS];
  wire logic vol_on_w = !(bs_mode_w && bypass_w);
  wire logic ramp_up_w = e_ramp[B_RAMP_UP_AFTER_ERROR];
  wire logic ramp_dn_w = e_ramp[B_RAMP_DOWN_BEFORE_FILTER];
  wire logic [2:0] filt_cfg_w = {e_mode[B_DEM_LO +: 2], e_ramp[B_ROLLOFF]};
  wire dvr_pol_t pol_w = dvr_pol_t'(e_mute[B_POL_LO +: 2]);
  // bitstream offers only immediate and soft ramp
  wire dvr_style_t sty_w = bs_mode_w
      ? (e_ramp[B_STY_LO + 1] ? STY_SOFT : STY_IMM)
      : dvr_style_t'(e_ramp[B_STY_LO +: 2]);

  // ==========================================================
  // pin synchronisers and edge finders
  logic [2:0] fc_q;
  logic [2:0] bc_q;
  logic [1:0] ms_q;
  logic [BS_W-1:0] bs_cnt_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fc_q <= 3'h0;
      bc_q <= 3'h0;
      ms_q <= 2'h0;
    end else begin
      fc_q <= {fc_q[1:0], frame_clock};
      bc_q <= {bc_q[1:0], bitstream_clock};
      ms_q <= {ms_q[0], mute_sense_a};
    end
  end
  wire logic frame_rise_w = fc_q[1] && !fc_q[2];
  wire logic bs_rise_w = bc_q[1] && !bc_q[2];
  wire logic [BS_W-1:0] bs_lim_w = bitstream_128x
      ? BS_W'(BS_STEP_CLKS_128X - 1) : BS_W'(BS_STEP_CLKS - 1);
  wire logic bs_tick_w = bs_rise_w && (bs_cnt_q >= bs_lim_w);
  // one 1/8 dB step per frame period gives 1 dB per 8 frames
  wire logic step_tick_w = bs_mode_w ? bs_tick_w : frame_rise_w;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bs_cnt_q <= '0;
    end else if (bs_rise_w) begin
      bs_cnt_q <= bs_tick_w ? '0 : bs_cnt_q + BS_W'(1);
    end
  end

  // ==========================================================
  // error and filter-change sequencing
  dvr_fstate_t fs_q;
  logic [RL_W-1:0] rl_cnt_q;
  logic [2:0] filt_q;
  logic [1:0] fm_q;
  logic [LEVEL_W-1:0] lvl_w [2];
  wire logic fm_chg_w = fm_w != fm_q;
  wire logic err_w = ratio_error || fm_chg_w;
  wire logic filt_start_w = (fs_q == FS_IDLE) && (filt_cfg_w != filt_q);
  wire logic both_muted_w = (lvl_w[0] == MUTE_LVL) && (lvl_w[1] == MUTE_LVL);
  wire logic force_mute_w = fs_q != FS_IDLE;
  wire logic filt_jump_w = filt_start_w && !ramp_dn_w;
  wire logic jump_w = err_w || filt_jump_w;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fs_q <= FS_IDLE;
      rl_cnt_q <= '0;
      filt_q <= 3'h0;
      fm_q <= RST_MODE[B_FM_LO +: 2];
    end else begin
      fm_q <= fm_w;
      unique case (fs_q)
        FS_IDLE: begin
          if (filt_start_w) begin
            fs_q <= ramp_dn_w ? FS_MUTING : FS_RELOAD;
          end
        end
        FS_MUTING: begin
          if (both_muted_w || low_pwr_w) begin
            fs_q <= FS_RELOAD;
          end
        end
        FS_RELOAD: begin
          filt_q <= filt_cfg_w;
          rl_cnt_q <= rl_cnt_q + RL_W'(1);
          if (rl_cnt_q == RL_W'(RELOAD_CYCLES - 1)) begin
            rl_cnt_q <= '0;
            fs_q <= FS_IDLE;
          end
        end
        default: fs_q <= FS_IDLE;
      endcase
    end
  end

  // ==========================================================
  // per-channel level engine, zero-cross timer and auto-mute
  logic [SAMPLE_W-1:0] samp_w [2];
  logic [7:0] code_w [2];
  logic cond_w [2];
  logic am_w [2];
  assign samp_w[0] = sample_a;
  assign samp_w[1] = sample_b;
  assign code_w[0] = e_att_a;
  assign code_w[1] = e_mix[B_FOLLOW] ? e_att_a : e_att_b;

  for (genvar ch = 0; ch < 2; ch++) begin : g_ch
    logic [LEVEL_W-1:0] level_q;
    logic [LEVEL_W-1:0] nxt;
    logic [ZC_W-1:0] zc_cnt_q;
    logic [AM_W-1:0] am_cnt_q;
    logic am_q;
    logic imm_q;
    logic sign_q;
    wire logic [SAMPLE_W-1:0] s = samp_w[ch];
    wire logic manual = e_mute[B_MUTE_A - ch];
    wire logic mute_req = manual || am_q;
    wire logic [LEVEL_W-1:0] target = (mute_req || force_mute_w)
        ? MUTE_LVL : att_to_level(code_w[ch]);
    wire logic busy = level_q != target;
    wire logic is_static = (s == '0) || (s == '1);
    wire logic zc = sample_strobe && ((s[SAMPLE_W-1] != sign_q) || s == '0);
    wire logic tmo = frame_rise_w
        && (zc_cnt_q == ZC_W'(ZC_TIMEOUT_SAMPLES - 1));
    wire logic zc_go = zc || tmo;
    wire dvr_style_t sty = imm_q ? STY_IMM : sty_w;

    always_comb begin
      unique case (sty)
        STY_IMM: nxt = target;
        STY_ZC: nxt = zc_go ? target : level_q;
        STY_SOFT: nxt = step_tick_w ? step_toward(level_q, target)
                                    : level_q;
        STY_SOFT_ZC: nxt = zc_go ? step_toward(level_q, target)
                                 : level_q;
      endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        level_q <= MUTE_LVL;
        imm_q <= 1'b0;
        sign_q <= 1'b0;
      end else begin
        if (sample_strobe) begin
          sign_q <= s[SAMPLE_W-1];
        end
        if (low_pwr_w || jump_w) begin
          level_q <= MUTE_LVL;
        end else if (busy) begin
          level_q <= nxt;
        end
        if (err_w) begin
          imm_q <= !ramp_up_w;
        end else if (!busy) begin
          imm_q <= 1'b0;
        end
      end
    end

    // the timer restarts on every applied change, so each soft step
    // gets its own full timeout window
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        zc_cnt_q <= '0;
      end else if (!busy || zc_go || sty == STY_IMM) begin
        zc_cnt_q <= '0;
      end else if (frame_rise_w) begin
        zc_cnt_q <= zc_cnt_q + ZC_W'(1);
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        am_cnt_q <= '0;
        am_q <= 1'b0;
      end else if (!e_mute[B_AUTOMUTE] || bs_mode_w) begin
        am_cnt_q <= '0;
        am_q <= 1'b0;
      end else if (sample_strobe) begin
        if (!is_static) begin
          am_cnt_q <= '0;
          am_q <= 1'b0;
        end else if (am_cnt_q == AM_W'(AUTO_MUTE_SAMPLES - 1)) begin
          am_q <= 1'b1;
        end else begin
          am_cnt_q <= am_cnt_q + AM_W'(1);
        end
      end
    end

    // the pin waits for the ramp to reach full mute
    assign cond_w[ch] = mute_req && (level_q == MUTE_LVL);
    assign lvl_w[ch] = level_q;
    assign am_w[ch] = am_q;
  end

  // ==========================================================
  // mute pins: polarity, joining and drive enable
  logic det_done_q;
  logic det_high_q;
  logic [1:0] det_cnt_q;
  wire logic pin_a_w = e_mute[B_JOIN] ? (cond_w[0] && cond_w[1])
                                      : cond_w[0];
  wire logic pin_b_w = e_mute[B_JOIN] ? (cond_w[0] && cond_w[1])
                                      : cond_w[1];
  // a pin biased high by the board means the mute sense is active low
  wire logic act_high_w = (pol_w == POL_HIGH)
      || (pol_w == POL_AUTO && !det_high_q);
  wire logic drive_w = (pol_w == POL_LOW) || (pol_w == POL_HIGH)
      || (pol_w == POL_AUTO && det_done_q);

  // sense is sampled a few cycles after release, before the pin is driven
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      det_cnt_q <= 2'h0;
      det_done_q <= 1'b0;
      det_high_q <= 1'b0;
    end else if (!det_done_q) begin
      det_cnt_q <= det_cnt_q + 2'h1;
      if (det_cnt_q == 2'h3) begin
        det_done_q <= 1'b1;
        det_high_q <= ms_q[1];
      end
    end
  end

  // ==========================================================
  // registered outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mute_out_a <= 1'b0;
      mute_out_b <= 1'b0;
      mute_out_a_oe <= 1'b0;
      mute_out_b_oe <= 1'b0;
      level_a <= MUTE_LVL;
      level_b <= MUTE_LVL;
      volume_active <= 1'b1;
      bitstream_bypass <= 1'b0;
      lp50_enable <= 1'b0;
      conversion_pause <= 1'b0;
      low_power_request <= 1'b0;
      register_control_enable <= 1'b0;
    end else begin
      mute_out_a <= act_high_w ? pin_a_w : !pin_a_w;
      mute_out_b <= act_high_w ? pin_b_w : !pin_b_w;
      mute_out_a_oe <= drive_w;
      mute_out_b_oe <= drive_w;
      level_a <= vol_on_w ? lvl_w[0] : '0;
      level_b <= vol_on_w ? lvl_w[1] : '0;
      volume_active <= vol_on_w;
      bitstream_bypass <= bs_mode_w && bypass_w;
      lp50_enable <= bs_mode_w && !bypass_w;
      conversion_pause <= fs_q == FS_RELOAD;
      low_power_request <= low_pwr_w;
      register_control_enable <= register_control_enable_w;
    end
  end

  assign status_w = {5'h00, mute_out_b, mute_out_a, conversion_pause,
                     am_w[1], am_w[0], lvl_w[1], lvl_w[0]};
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign interp_rolloff_sel = filt_q[0];
  assign deemph_select = filt_q[2:1];
  assign func_mode = fm_q;

endmodule : dvr_ctrl

`default_nettype wire

/* File: verilog/dvr_pkg.sv */
// constants, field layout and state types of the volume, mute and ramp block
// assumes an apb master on pclk, one aligned 32-bit word per register
//
// What this block does
// - join bit clear: own mute pin per channel; set: both pins show AND
// - manual mute ramps by selected style; pin asserts only once ramp done
// - polarity field: 00 auto-detect on pin a, 01 reserved, 10 low, 11 high
// - mute pins float in reset; driven only after a polarity is known
// - 8-bit attenuation per channel, resets to 0 dB, half-dB steps to -127.5
// - style field resets to 10; bitstream offers only immediate or soft ramp
// - immediate style applies any level change at once in one step
// - zero-cross style applies change at crossing or after 512 sample timeout
// - soft ramp on samples steps 1/8 dB once per frame-clock period
// - bitstream soft ramp: 1 dB per 512 clocks, 1024 clocks at 128x
// - soft ramp on crossings: each 1/8 step at crossing or 512 timeout
// - after ratio error or mode change unmute by style, or at once if clear
// - filter change pauses; mute and unmute by style, or mute at once
// - roll-off bit 0 selects fast, 1 selects slow interpolation filter
// - bypass sends bitstream straight on; volume off, 50k filter gone
// - low-power bit resets to 1, keeps registers, ignored without port enable
// - port enable resets to 0; once set, registers steer the block
// - freeze holds written values; clearing it applies all at once
// - 8192 static samples mute a channel; one live sample releases it
// - b-follows-a: channel a attenuation drives both channels

package dvr_pkg;

  // ==========================================================
  // register indices; byte address = 4 * index
  localparam int IDX_MODE = 2;
  localparam int IDX_MIX = 3;
  localparam int IDX_MUTE = 4;
  localparam int IDX_ATT_A = 5;
  localparam int IDX_ATT_B = 6;
  localparam int IDX_RAMP = 7;
  localparam int IDX_PWR = 8;
  localparam int IDX_STAT = 16;

  // ==========================================================
  // reset values and writable bits
  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [7:0] RST_MIX = 8'h09;
  localparam logic [7:0] RST_MUTE = 8'hC0;
  localparam logic [7:0] RST_ATT = 8'h00;
  localparam logic [7:0] RST_RAMP = 8'hB0;
  localparam logic [7:0] RST_PWR = 8'h80;
  localparam logic [7:0] WM_MODE = 8'h0F;
  localparam logic [7:0] WM_MUTE = 8'hFB;
  localparam logic [7:0] WM_RAMP = 8'hF5;
  localparam logic [7:0] WM_PWR = 8'hE0;
  localparam logic [7:0] WM_ALL = 8'hFF;

  // ==========================================================
  // field positions
  localparam int B_FM_LO = 0;
  localparam int B_DEM_LO = 2;
  localparam int B_FOLLOW = 7;
  localparam int B_AUTOMUTE = 7;
  localparam int B_JOIN = 5;
  localparam int B_MUTE_A = 4;
  localparam int B_MUTE_B = 3;
  localparam int B_POL_LO = 0;
  localparam int B_STY_LO = 6;
  localparam int B_RAMP_UP_AFTER_ERROR = 5;
  localparam int B_RAMP_DOWN_BEFORE_FILTER = 4;
  localparam int B_ROLLOFF = 2;
  localparam int B_BYPASS = 0;
  localparam int B_LOWPWR = 7;
  localparam int B_REGISTER_CONTROL_ENABLE = 6;
  localparam int B_FREEZE = 5;
  localparam logic [1:0] FM_BITSTREAM = 2'b11;

  // ==========================================================
  // levels in 1/8 dB units; one code step is 1/2 dB
  localparam int LEVEL_W = 11;
  localparam logic [LEVEL_W-1:0] MUTE_LVL = 11'h400;
  localparam int EIGHTHS_PER_CODE = 4;

  // ==========================================================
  // timing, in sample periods or clock periods
  localparam int ZC_TIMEOUT_SAMPLES = 512;
  localparam int STEPS_PER_DB = 8;
  localparam int BS_CLKS_PER_DB = 512;
  localparam int BS_CLKS_PER_DB_128X = 1024;
  localparam int BS_STEP_CLKS = BS_CLKS_PER_DB / STEPS_PER_DB;
  localparam int BS_STEP_CLKS_128X = BS_CLKS_PER_DB_128X / STEPS_PER_DB;
  localparam int RELOAD_CYCLES = 64;

  typedef enum logic [1:0] {
    STY_IMM = 2'b00,
    STY_ZC = 2'b01,
    STY_SOFT = 2'b10,
    STY_SOFT_ZC = 2'b11
  } dvr_style_t;

  typedef enum logic [1:0] {
    POL_AUTO = 2'b00,
    POL_RSVD = 2'b01,
    POL_LOW = 2'b10,
    POL_HIGH = 2'b11
  } dvr_pol_t;

  typedef enum logic [1:0] {
    FS_IDLE = 2'b00,
    FS_MUTING = 2'b01,
    FS_RELOAD = 2'b10
  } dvr_fstate_t;

  function automatic logic [LEVEL_W-1:0] att_to_level(input logic [7:0] c);
    att_to_level = LEVEL_W'(c) * LEVEL_W'(EIGHTHS_PER_CODE);
  endfunction : att_to_level

  function automatic logic [LEVEL_W-1:0] step_toward(
      input logic [LEVEL_W-1:0] cur, input logic [LEVEL_W-1:0] tgt);
    if (cur < tgt) begin
      step_toward = cur + LEVEL_W'(1);
    end else if (cur > tgt) begin
      step_toward = cur - LEVEL_W'(1);
    end else begin
      step_toward = cur;
    end
  endfunction : step_toward

endpackage : dvr_pkg

/* File: dv/dvr_ctrl_chk.sv */
// checker of dvr_ctrl: apb, mute pins, levels, reload
// bound into dvr_ctrl; sees its ports only
`timescale 1ns/1ps
`default_nettype none
module dvr_ctrl_chk
  import dvr_pkg::*;
(
  input wire logic pclk, // clock
  input wire logic presetn, // reset
  input wire logic psel, // apb
  input wire logic penable, // apb
  input wire logic pready, // apb
  input wire logic pslverr, // apb
  input wire logic mute_out_a_oe, // pin a
  input wire logic mute_out_b_oe, // pin b
  input wire logic [LEVEL_W-1:0] level_a, // level a
  input wire logic [LEVEL_W-1:0] level_b, // level b
  input wire logic bitstream_bypass, // bypass
  input wire logic volume_active, // volume
  input wire logic conversion_pause, // reload
  input wire logic low_power_request, // low power
  input wire logic register_control_enable // port enable
);
  logic [7:0] pause_n_q;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ====================
  // pause length: too long for a repetition
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pause_n_q <= 8'h00;
    else if (conversion_pause) pause_n_q <= pause_n_q + 8'h01;
    else pause_n_q <= 8'h00;
  end
  a_ready_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_err_access: assert property (pslverr |-> pready && psel && penable)
    else $error("error outside access");
  a_float_release: assert property ($rose(presetn) |->
    !mute_out_a_oe && !mute_out_b_oe) else $error("pin driven in reset");
  a_oe_paired: assert property (mute_out_a_oe == mute_out_b_oe)
    else $error("pin enables differ");
  a_bypass_vol: assert property (bitstream_bypass |-> !volume_active)
    else $error("volume on in bypass");
  a_vol_idle: assert property (!volume_active |-> level_a == '0 &&
    level_b == '0) else $error("level while volume off");
  a_pwr_port: assert property (low_power_request |->
    register_control_enable) else $error("low power without port");
  a_pause_len: assert property ($fell(conversion_pause) |->
    pause_n_q == 8'h40) else $error("pause length wrong");
  a_pause_mute: assert property ($rose(conversion_pause) && volume_active
    |-> level_a == MUTE_LVL && level_b == MUTE_LVL)
    else $error("reload while not muted");
  c_pause: cover property ($rose(conversion_pause));
  c_pins: cover property (mute_out_a_oe && mute_out_b_oe);
  c_bypass: cover property (bitstream_bypass);
endmodule : dvr_ctrl_chk
bind dvr_ctrl dvr_ctrl_chk dvr_ctrl_chk_inst (.pclk, .presetn, .psel,
  .penable, .pready, .pslverr, .mute_out_a_oe, .mute_out_b_oe, .level_a,
  .level_b, .bitstream_bypass, .volume_active, .conversion_pause,
  .low_power_request, .register_control_enable);
`default_nettype wire

/* File: dv/dvr_src_model.sv */
// serial audio source: free frame clock, bitstream clock and samples
// samples flip sign each frame: every frame crosses zero
`timescale 1ns/1ps
`default_nettype none
module dvr_src_model
  import dvr_pkg::*;
(
  input wire logic pclk, // master clock
  input wire logic presetn, // reset, active low
  input wire logic quiet, // send static zero samples
  output logic frame_clock, // 200 ns period
  output logic bitstream_clock, // unrelated to pclk
  output logic [23:0] sample_a, // channel a
  output logic [23:0] sample_b, // channel b
  output logic sample_strobe // one pulse per frame
);
  logic [2:0] sync_q;
  logic [23:0] data_q;
  // ====================
  // audio clocks run free, phase unrelated to pclk
  initial frame_clock = 1'b0;
  initial bitstream_clock = 1'b0;
  always #100 frame_clock = ~frame_clock;
  always #37 bitstream_clock = ~bitstream_clock;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_q <= 3'h0;
      data_q <= 24'h000123;
      sample_strobe <= 1'b0;
    end else begin
      sync_q <= {sync_q[1:0], frame_clock};
      sample_strobe <= sync_q[1] && !sync_q[2];
      if (sync_q[1] && !sync_q[2]) data_q <= ~data_q;
    end
  end
  assign sample_a = quiet ? 24'h000000 : data_q;
  assign sample_b = quiet ? 24'h000000 : data_q;
endmodule : dvr_src_model
`default_nettype wire

/* File: dv/dvr_ctrl_tb.sv */
// bench of dvr_ctrl: apb host, source model, pin pull-up
// assumes the source model and bound checker beside it
`timescale 1ns/1ps
`default_nettype none
module dvr_ctrl_tb
  import dvr_pkg::*;
;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, ratio_error = 1'b0, quiet = 1'b0;
  logic bitstream_128x = 1'b0, err_v;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd_v, seed = 32'h00002F3B;
  logic pready, pslverr, frame_clock, bitstream_clock, sample_strobe;
  logic mute_out_a, mute_out_a_oe, mute_out_b, mute_out_b_oe, mute_sense_a;
  logic interp_rolloff_sel, bitstream_bypass, lp50_enable, volume_active;
  logic conversion_pause, low_power_request, register_control_enable;
  logic [23:0] sample_a, sample_b;
  logic [10:0] level_a, level_b;
  logic [1:0] deemph_select, func_mode;
  int n_errors = 0, total_checks = 0;
  // pull-up on pin a when not driven
  assign mute_sense_a = mute_out_a_oe ? mute_out_a : 1'b1;
  always #12.5 pclk = ~pclk;
  dvr_ctrl #(.AUTO_MUTE_SAMPLES(16)) dvr_ctrl_inst (.pclk, .presetn, .paddr,
    .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .frame_clock, .bitstream_clock, .sample_a, .sample_b, .sample_strobe,
    .ratio_error, .bitstream_128x, .mute_sense_a, .mute_out_a,
    .mute_out_a_oe, .mute_out_b, .mute_out_b_oe, .level_a, .level_b,
    .interp_rolloff_sel, .deemph_select, .func_mode, .bitstream_bypass,
    .lp50_enable, .volume_active, .conversion_pause, .low_power_request,
    .register_control_enable);
  dvr_src_model dvr_src_model_inst (.pclk, .presetn, .quiet, .frame_clock,
    .bitstream_clock, .sample_a, .sample_b, .sample_strobe);
  // ====================
  // tasks
  task automatic chk(input string n, input logic [31:0] s, e);
    total_checks++;
    if (s !== e) begin
      n_errors++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, 24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    chk("pready", pready, 1);
    {rd_v, err_v} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
  endtask : apb
  task automatic wr(input logic [7:0] a, d);
    apb(1'b1, a, d);
    repeat (4) @(posedge pclk);
  endtask : wr
  task automatic rdc(input logic [7:0] a, e);
    apb(1'b0, a, 8'h00);
    chk("rdata", rd_v, {24'h0, e});
  endtask : rdc
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd
  function automatic logic [31:0] lvl(input logic [7:0] c);
    return {22'h0, c, 2'b00};
  endfunction : lvl
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish
  // ====================
  // main sequence
  initial begin
    logic [7:0] c;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("lp", {low_power_request, register_control_enable}, 0);
    rdc(8'h14, 8'h00);
    rdc(8'h1C, 8'hB0);
    rdc(8'h20, 8'h80);
    apb(1'b0, 8'h30, 8'h00);
    chk("slverr", err_v, 1);
    for (int s = 3; s >= 0; s--) begin
      wr(8'h1C, {s[1:0], 6'h30});
      rdc(8'h1C, {s[1:0], 6'h30});
    end
    wr(8'h20, 8'hC0);
    chk("lp", low_power_request, 1);
    wr(8'h20, 8'h40);
    chk("port", {register_control_enable, low_power_request}, 2);
    for (int i = 0; i < 5; i++) begin
      c = (i == 0) ? 8'hFF : rnd();
      wr(8'h14, c);
      chk("level_a", level_a, lvl(c));
    end
    ratio_error <= 1'b1;
    @(posedge pclk);
    ratio_error <= 1'b0;
    repeat (6) @(posedge pclk);
    chk("error", level_a, lvl(c));
    wr(8'h20, 8'h60);
    wr(8'h14, ~c);
    chk("frozen", level_a, lvl(c));
    wr(8'h20, 8'h40);
    chk("thawed", level_a, lvl(~c));
    wr(8'h0C, 8'h89);
    chk("level_b", level_b, lvl(~c));
    wr(8'h0C, 8'h09);
    for (int p = 2; p < 4; p++) begin
      wr(8'h10, {6'h24, p[1:0]});
      chk("pin_a", {mute_out_a_oe, mute_out_a, mute_out_b},
        {1'b1, p[0], !p[0]});
      wr(8'h10, {6'h2C, p[1:0]});
      chk("join", mute_out_a, !p[0]);
      wr(8'h10, {6'h2E, p[1:0]});
      chk("both", {mute_out_a, mute_out_b}, {2{p[0]}});
    end
    wr(8'h10, 8'h81);
    chk("rsvd", mute_out_a_oe, 0);
    wr(8'h10, 8'h80);
    chk("auto", mute_out_a, 1);
    wr(8'h14, 8'h10);
    wr(8'h1C, 8'hB0);
    wr(8'h14, 8'h00);
    repeat (160) @(posedge pclk);
    chk("ramp", level_a > 11'h20 && level_a < 11'h40, 1);
    wr(8'h14, 8'h08);
    chk("retarget", level_a > 11'h20 && level_a < 11'h40, 1);
    repeat (400) @(posedge pclk);
    chk("ramp_end", level_a, 32'h20);
    wr(8'h1C, 8'h34);
    repeat (40) if (conversion_pause !== 1'b1) @(posedge pclk);
    chk("pause", conversion_pause, 1);
    repeat (100) if (conversion_pause !== 1'b0) @(posedge pclk);
    chk("rolloff", {conversion_pause, interp_rolloff_sel}, 1);
    quiet <= 1'b1;
    repeat (200) @(posedge pclk);
    apb(1'b0, 8'h40, 8'h00);
    chk("automute", rd_v[22], 1);
    quiet <= 1'b0;
    repeat (40) @(posedge pclk);
    apb(1'b0, 8'h40, 8'h00);
    chk("release", rd_v[22], 0);
    wr(8'h08, 8'h03);
    chk("mode", func_mode, 3);
    wr(8'h1C, 8'h35);
    chk("bypass", {bitstream_bypass, volume_active, lp50_enable}, 4);
    tally_and_finish();
  end
  initial begin
    #300000;
    n_errors++;
    tally_and_finish();
  end
endmodule : dvr_ctrl_tb
`default_nettype wire
